//--- sbs_pkg.sv
`default_nettype none
// ------------------------------------------------------------
// Shared constants of the burst SRAM port
// ------------------------------------------------------------
package sbs_pkg;
    // Default organisation: four lanes of a byte plus parity
    localparam int SBS_LANES = 4;
    localparam int SBS_LANE_W = 9;
    localparam int SBS_ADDR_W = 19;
    localparam int SBS_MAX_LANES = 4;
    // Burst beat positions on the two low address bits
    localparam logic [1:0] SBS_BEAT_ZERO = 2'h0;
    localparam logic [1:0] SBS_BEAT_ONE = 2'h1;
    localparam logic [1:0] SBS_BEAT_STEP = 2'h1;
    // Reset values of the control state
    localparam logic SBS_ACTIVE_RST = 1'h0;
    localparam logic SBS_READ_RST = 1'h0;
    localparam logic SBS_VALID_RST = 1'h0;
    // Operation taken in one clock cycle
    typedef enum logic [2:0] {
        SBS_OP_HOLD,
        SBS_OP_DESEL,
        SBS_OP_READ,
        SBS_OP_WRITE,
        SBS_OP_SLEEP
    } sbs_op_t;
endpackage
`default_nettype wire

//--- sbs_burst_order.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Low address bits for a beat of a four-beat burst
// ------------------------------------------------------------
module sbs_burst_order (
    input wire logic [1:0] start_bits,   // Externally loaded low bits
    input wire logic [1:0] beat,         // Beat number within burst
    input wire logic linear_order_sel_n, // Low selects linear order
    output logic [1:0] addr_bits         // Address bits of this beat
);
    // Linear wraps upward modulo four, interleaved flips bits
    always_comb begin
        if (!linear_order_sel_n) begin
            addr_bits = start_bits + beat;
        end else begin
            addr_bits = start_bits ^ beat;
        end
    end
endmodule // sbs_burst_order
`default_nettype wire

//--- sbs_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Array with lane write enables and a registered read port
// ------------------------------------------------------------
module sbs_mem #(
    parameter int LANES = sbs_pkg::SBS_LANES,
    parameter int LANE_W = sbs_pkg::SBS_LANE_W,
    parameter int ADDR_W = sbs_pkg::SBS_ADDR_W
) (
    input wire logic mclk,
    input wire logic wr_en,                      // Write this cycle
    input wire logic [LANES-1:0] wr_lanes,       // Lanes to write
    input wire logic [ADDR_W-1:0] wr_addr,       // Write word
    input wire logic [LANES*LANE_W-1:0] wr_data, // Write data
    input wire logic rd_en,                      // Read this cycle
    input wire logic [ADDR_W-1:0] rd_addr,       // Read word
    output logic [LANES*LANE_W-1:0] rd_data      // Registered data
);
    // ------------------------------------------------------------
    // One array per lane, each with its own write enable
    // ------------------------------------------------------------
    // A separate array per lane keeps each array in one process;
    // nothing clears the arrays, so contents survive standby
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [LANE_W-1:0] lane_mem_reg [0:(2**ADDR_W)-1];
        always_ff @(posedge mclk) begin
            if (wr_en && wr_lanes[g]) begin
                lane_mem_reg[wr_addr] <=
                    wr_data[g*LANE_W +: LANE_W];
            end
            // Output register gives the pipelined data stage
            if (rd_en) begin
                rd_data[g*LANE_W +: LANE_W] <=
                    lane_mem_reg[rd_addr];
            end
        end
    end
endmodule // sbs_mem
`default_nettype wire

//--- sbs_port.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Controller strobe aborts burst, loads, reads or writes
// - Controller strobe with primary select high deselects
// - Processor strobe loads address, starts read if selected
// - Processor strobe ignored while primary select high
// - Processor strobe with secondary selects off deselects
// - Burst step low advances the burst counter
// - Burst step high holds address, giving waits
// - Byte strobes count only with lane gate low
// - Each byte strobe writes its own lane
// - Global write writes whole word regardless
// - Chip selects sampled only on address loads
// - Enabled means high select high, both lows low
// - All synchronous inputs registered on rising edge
// - Order pin low linear, high interleaved
// - Output enable gates data drivers without clock
// - Sleep request gives standby keeping contents
// - Sleep request makes all other inputs ignored
// - Two or four lanes, write data registered
// - Four beats, xor or modulo-four count
// - Data pins float when deselected or asleep
module sbs_port #(
    parameter int LANES = sbs_pkg::SBS_LANES,   // 2 or 4 byte lanes
    parameter int LANE_W = sbs_pkg::SBS_LANE_W, // 8, or 9 with parity
    parameter int ADDR_W = sbs_pkg::SBS_ADDR_W  // Word address width
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [ADDR_W-3:0] addr_upper,   // Upper word address
    input wire logic addr_bit1,                 // Address bit one
    input wire logic addr_bit0,                 // Address bit zero
    input wire logic ctrl_addr_load_n,          // Controller strobe
    input wire logic proc_addr_load_n,          // Processor strobe
    input wire logic burst_step_n,              // Burst advance
    input wire logic chip_sel_main_n,           // Primary select
    input wire logic chip_sel_low_two,          // Secondary low select
    input wire logic chip_sel_hi,               // Secondary high select
    input wire logic lane_a_wr_n,
    input wire logic lane_b_wr_n,
    input wire logic lane_c_wr_n,
    input wire logic lane_d_wr_n,
    input wire logic lane_wr_gate_n,            // Byte strobe gate
    input wire logic all_byte_wr_n,             // Global write
    input wire logic linear_order_sel_n,        // Burst order select
    input wire logic out_en_n,                  // Output enable
    input wire logic sleep_req,                 // Standby request
    input wire logic [LANES*LANE_W-1:0] data_in,
    output logic [LANES*LANE_W-1:0] data_out,
    output logic data_oe
);
    // ------------------------------------------------------------
    // State and decode types
    // ------------------------------------------------------------
    // Whole control state of the port in one record
    typedef struct packed {
        logic [ADDR_W-3:0] upper; // Loaded upper address
        logic [1:0] base;         // Loaded low bits, burst start
        logic [1:0] beat;         // Beats stepped since the load
        logic [1:0] low;          // Low bits now in use
        logic active;             // Selected since the last load
        logic read_act;           // Read issued this cycle
        logic rd_valid;           // Read data on the output stage
    } sbs_state_t;

    sbs_state_t state_reg;  // Registered state
    sbs_state_t state_next; // Its next value
    sbs_pkg::sbs_op_t op;   // Operation of this cycle
    logic load;             // External address is taken now
    logic step;             // Burst counter advances now
    logic sel_all;          // All three selects enabling
    logic [LANES-1:0] wr_mask;   // Lanes asked for by the strobes
    logic [LANES-1:0] wr_lanes;  // Lanes written this cycle
    logic [1:0] order_bits;      // Low bits from the ordering
    logic wr_en;                 // Array write strobe
    logic [ADDR_W-1:0] wr_addr;  // Array write address
    logic [ADDR_W-1:0] rd_addr;  // Array read address

    // ------------------------------------------------------------
    // Write strobe decode
    // ------------------------------------------------------------
    // Global write wins, else byte strobes only through the gate
    function automatic logic [sbs_pkg::SBS_MAX_LANES-1:0] lane_mask(
        input logic gw_n,
        input logic gate_n,
        input logic [sbs_pkg::SBS_MAX_LANES-1:0] bw_n
    );
        logic [sbs_pkg::SBS_MAX_LANES-1:0] m;
        m = '0;
        if (!gw_n) begin
            m = '1;
        end else if (!gate_n) begin
            m = ~bw_n;
        end
        return m;
    endfunction

    // Unused upper strobes of a two-lane part fall away here
    assign wr_mask = LANES'(lane_mask(all_byte_wr_n, lane_wr_gate_n,
        {lane_d_wr_n, lane_c_wr_n, lane_b_wr_n, lane_a_wr_n}));

    // Enabled needs the high select high and both lows low
    assign sel_all = !chip_sel_main_n && !chip_sel_low_two &&
        chip_sel_hi;

    // ------------------------------------------------------------
    // Burst ordering
    // ------------------------------------------------------------
    // Ordering is worked out for the beat about to be used
    sbs_burst_order u_order (
        .start_bits(state_next.base),
        .beat(state_next.beat),
        .linear_order_sel_n(linear_order_sel_n),
        .addr_bits(order_bits)
    );

    // ------------------------------------------------------------
    // Cycle decode and next state
    // ------------------------------------------------------------
    // Strobe priority: processor first, then controller, then burst
    always_comb begin
        state_next = state_reg;
        op = sbs_pkg::SBS_OP_HOLD;
        load = 1'h0;
        step = 1'h0;
        if (sleep_req) begin
            // Standby: inputs ignored, pipeline emptied
            op = sbs_pkg::SBS_OP_SLEEP;
            state_next.read_act = 1'h0;
            state_next.rd_valid = 1'h0;
        end else begin
            state_next.rd_valid = state_reg.read_act;
            if (!proc_addr_load_n && !chip_sel_main_n) begin
                // Processor strobe: a read if selected, else a deselect; strobes not looked at
                load = 1'h1;
                if (sel_all) begin
                    op = sbs_pkg::SBS_OP_READ;
                end else begin
                    op = sbs_pkg::SBS_OP_DESEL;
                end
            end else if (!ctrl_addr_load_n) begin
                // Controller strobe: read or write at the new address, else a deselect
                load = 1'h1;
                if (!sel_all) begin
                    op = sbs_pkg::SBS_OP_DESEL;
                end else if (wr_mask != '0) begin
                    op = sbs_pkg::SBS_OP_WRITE;
                end else begin
                    op = sbs_pkg::SBS_OP_READ;
                end
            end else if (state_reg.active) begin
                // Burst continues; selects are not looked at here
                step = !burst_step_n;
                if (wr_mask != '0) begin
                    op = sbs_pkg::SBS_OP_WRITE;
                end else begin
                    op = sbs_pkg::SBS_OP_READ;
                end
            end
            // Address path
            if (load) begin
                state_next.upper = addr_upper;
                state_next.base = {addr_bit1, addr_bit0};
                state_next.beat = sbs_pkg::SBS_BEAT_ZERO;
            end else if (step) begin
                state_next.beat = state_reg.beat +
                    sbs_pkg::SBS_BEAT_STEP;
            end
            // A deselect ends the burst until the next load
            if (op == sbs_pkg::SBS_OP_DESEL) begin
                state_next.active = 1'h0;
            end else if (load) begin
                state_next.active = 1'h1;
            end
            state_next.read_act = (op == sbs_pkg::SBS_OP_READ);
        end
        // Held beats keep their bits; the order pin is static
        state_next.low = order_bits;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Whole record cleared to zero, address included; control bits then set from the package reset values
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= '0;
            state_reg.active <= sbs_pkg::SBS_ACTIVE_RST;
            state_reg.read_act <= sbs_pkg::SBS_READ_RST;
            state_reg.rd_valid <= sbs_pkg::SBS_VALID_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Array and data pins
    // ------------------------------------------------------------
    // Writes land on the edge that samples the data, no later step
    assign wr_en = (op == sbs_pkg::SBS_OP_WRITE);
    assign wr_lanes = wr_mask;
    assign wr_addr = {state_next.upper, state_next.low};
    // Reads use the registered address, data one edge later
    assign rd_addr = {state_reg.upper, state_reg.low};

    sbs_mem #(
        .LANES(LANES),
        .LANE_W(LANE_W),
        .ADDR_W(ADDR_W)
    ) u_mem (
        .mclk(mclk),
        .wr_en(wr_en),
        .wr_lanes(wr_lanes),
        .wr_addr(wr_addr),
        .wr_data(data_in),
        .rd_en(state_reg.read_act),
        .rd_addr(rd_addr),
        .rd_data(data_out)
    );

    // Enable is pure logic so the drivers follow the pins at once
    assign data_oe = state_reg.rd_valid && !out_en_n &&
        !sleep_req;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    proc_load_a: assert property (
        (!sleep_req && !proc_addr_load_n && !chip_sel_main_n && sel_all)
        |=> (state_reg.read_act && state_reg.active &&
        state_reg.upper == $past(addr_upper) &&
        state_reg.beat == sbs_pkg::SBS_BEAT_ZERO))
        else $error("processor strobe did not start a read");

    proc_ignore_a: assert property (
        (!sleep_req && !proc_addr_load_n && chip_sel_main_n &&
        ctrl_addr_load_n) |=> $stable(state_reg.upper) &&
        $stable(state_reg.base))
        else $error("processor strobe taken with primary select high");

    deselect_a: assert property (
        (!sleep_req && !ctrl_addr_load_n && proc_addr_load_n &&
        !sel_all) |=> !state_reg.active ##1 !state_reg.rd_valid)
        else $error("controller strobe failed to deselect");

    desel_proc_a: assert property (
        (!sleep_req && !proc_addr_load_n && !chip_sel_main_n &&
        !sel_all) |-> !wr_en ##1 (!state_reg.active &&
        !state_reg.read_act))
        else $error("processor strobe failed to deselect");

    burst_step_a: assert property (
        (!sleep_req && proc_addr_load_n && ctrl_addr_load_n &&
        state_reg.active && !burst_step_n) |=> (state_reg.beat ==
        $past(state_reg.beat) + sbs_pkg::SBS_BEAT_STEP))
        else $error("burst counter did not advance");

    burst_hold_a: assert property (
        (!sleep_req && proc_addr_load_n && ctrl_addr_load_n &&
        burst_step_n) [*2] |=> $stable(state_reg.low))
        else $error("burst address moved during wait");

    gate_off_a: assert property (
        (all_byte_wr_n && lane_wr_gate_n) |-> !wr_en)
        else $error("write without global write or gate");

    lane_map_a: assert property (
        (wr_en && all_byte_wr_n) |-> (wr_lanes ==
        LANES'(~{lane_d_wr_n, lane_c_wr_n, lane_b_wr_n, lane_a_wr_n})))
        else $error("written lanes differ from strobes");

    global_wr_a: assert property (
        (!sleep_req && !ctrl_addr_load_n && proc_addr_load_n &&
        sel_all && !all_byte_wr_n) |-> (wr_en && wr_lanes == '1))
        else $error("global write did not write all lanes");

    order_lin_a: assert property (
        (state_reg.active && state_reg.beat == sbs_pkg::SBS_BEAT_ONE &&
        !linear_order_sel_n) |-> (state_reg.low ==
        state_reg.base + sbs_pkg::SBS_BEAT_ONE))
        else $error("linear burst order wrong");

    order_int_a: assert property (
        (state_reg.active && state_reg.beat == sbs_pkg::SBS_BEAT_ONE &&
        linear_order_sel_n) |-> (state_reg.low ==
        (state_reg.base ^ sbs_pkg::SBS_BEAT_ONE)))
        else $error("interleaved burst order wrong");

    read_pipe_a: assert property (
        (op == sbs_pkg::SBS_OP_READ) ##1 !sleep_req |=>
        state_reg.rd_valid)
        else $error("read data not staged one cycle later");

    sleep_float_a: assert property (
        sleep_req |-> !data_oe && !wr_en)
        else $error("pins driven or array written while asleep");

    sleep_ignore_a: assert property (
        sleep_req |=> $stable(state_reg.upper) && $stable(state_reg.beat)
        && !state_reg.rd_valid)
        else $error("inputs acted on while asleep");

    oe_gate_a: assert property (
        out_en_n |-> !data_oe)
        else $error("data driven with output enable high");

    proc_read_c: cover property (
        (op == sbs_pkg::SBS_OP_READ && !proc_addr_load_n) ##2 data_oe);
    ctrl_write_c: cover property (
        (op == sbs_pkg::SBS_OP_WRITE && !ctrl_addr_load_n));
    full_burst_c: cover property (
        load ##1 step [*3]);
    sleep_c: cover property (
        state_reg.active ##1 sleep_req ##1 !sleep_req);
endmodule // sbs_port
`default_nettype wire

//--- sbs_master.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Bus master model: one bus cycle per clock, pins set after edge
// ------------------------------------------------------------
module sbs_master (
    input wire logic mclk,
    output logic [sbs_pkg::SBS_ADDR_W-3:0] addr_upper,
    output logic addr_bit1,
    output logic addr_bit0,
    output logic ctrl_addr_load_n,
    output logic proc_addr_load_n,
    output logic burst_step_n,
    output logic chip_sel_main_n,
    output logic chip_sel_low_two,
    output logic chip_sel_hi,
    output logic lane_a_wr_n,
    output logic lane_b_wr_n,
    output logic lane_c_wr_n,
    output logic lane_d_wr_n,
    output logic lane_wr_gate_n,
    output logic all_byte_wr_n,
    output logic linear_order_sel_n,
    output logic out_en_n,
    output logic sleep_req,
    output logic [sbs_pkg::SBS_LANES*sbs_pkg::SBS_LANE_W-1:0] data_in
);
    // Idle bus at time zero: strobes high, interleaved order
    initial begin
        {ctrl_addr_load_n, proc_addr_load_n, burst_step_n} = 3'h7;
        {chip_sel_main_n, chip_sel_low_two, chip_sel_hi} = 3'h6;
        {all_byte_wr_n, lane_wr_gate_n} = 2'h3;
        {lane_d_wr_n, lane_c_wr_n, lane_b_wr_n, lane_a_wr_n} = 4'hF;
        {addr_upper, addr_bit1, addr_bit0} = '0;
        data_in = '0;
        {linear_order_sel_n, out_en_n, sleep_req} = 3'h4;
    end

    // One cycle; kind 1 is the controller strobe, 2 the processor
    task automatic cyc(input logic [1:0] kind,
            input logic [sbs_pkg::SBS_ADDR_W-1:0] a, input logic [2:0] sel,
            input logic [5:0] wr, input logic step_n,
            input logic [sbs_pkg::SBS_LANES*sbs_pkg::SBS_LANE_W-1:0] d);
        @(posedge mclk);
        ctrl_addr_load_n <= (kind != 2'h1);
        proc_addr_load_n <= (kind != 2'h2);
        {addr_upper, addr_bit1, addr_bit0} <= a;
        {chip_sel_main_n, chip_sel_low_two, chip_sel_hi} <= sel;
        // Byte strobes travel with the address of the same cycle
        {all_byte_wr_n, lane_wr_gate_n} <= wr[5:4];
        {lane_d_wr_n, lane_c_wr_n, lane_b_wr_n, lane_a_wr_n} <= wr[3:0];
        burst_step_n <= step_n;
        // A released data bus shows the inverse, never a stale copy
        data_in <= (wr[5] && wr[4]) ? ~data_in : d;
    endtask

    // Order pin is only moved while the port is held in reset
    task automatic misc(input logic oe_n, input logic slp, input logic lin);
        out_en_n <= oe_n;
        sleep_req <= slp;
        linear_order_sel_n <= lin;
    endtask
endmodule // sbs_master
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ------------------------------------------------------------
    // Constants and row layout
    // ------------------------------------------------------------
    localparam int DW = sbs_pkg::SBS_LANES * sbs_pkg::SBS_LANE_W;
    localparam int AW = sbs_pkg::SBS_ADDR_W;
    localparam logic [DW-1:0] D4 = 36'h111111111;
    localparam logic [DW-1:0] D5 = 36'h222222222;
    localparam logic [DW-1:0] D6 = 36'h333333333;
    localparam logic [DW-1:0] D7 = 36'h444444444;
    localparam logic [DW-1:0] DN = 36'h5A5A5A5A5;
    localparam logic [DW-1:0] DF = 36'hFFFFFFFFF;
    // Lanes a and c taken from DF, b and d kept from D4
    localparam logic [DW-1:0] DM = {D4[35:27], DF[26:18], D4[17:9], DF[8:0]};
    // Selects {main_n, low_two, hi}; writes {gw_n, gate_n, d..a}
    localparam logic [2:0] SON = 3'h1, SMAIN = 3'h5, SHI = 3'h0;
    localparam logic [2:0] SLOW = 3'h3, SOFF = 3'h6;
    localparam logic [5:0] RD = 6'h3F, GW = 6'h1F, BAC = 6'h2A, NOG = 6'h30;
    typedef struct packed {
        logic [1:0] k; logic [AW-1:0] a; logic [2:0] s; logic [5:0] w;
        logic st; logic [DW-1:0] d; logic ev; logic [DW-1:0] ed;
        logic [1:0] x;
    } sbs_row_t;

    logic mclk = 1'b0, srst = 1'b1, lin_sel = 1'b1, chk_on = 1'b0;
    logic [AW-3:0] addr_upper;
    logic addr_bit1, addr_bit0, ctrl_addr_load_n, proc_addr_load_n;
    logic burst_step_n, chip_sel_main_n, chip_sel_low_two, chip_sel_hi;
    logic lane_a_wr_n, lane_b_wr_n, lane_c_wr_n, lane_d_wr_n;
    logic lane_wr_gate_n, all_byte_wr_n, linear_order_sel_n;
    logic out_en_n, sleep_req, data_oe;
    logic [DW-1:0] data_in, data_out, cur_d = '0, pd0, pd1;
    logic cur_v = 1'b0;
    logic [1:0] pv = 2'h0;
    int err_count = 0, samples_checked = 0;
    sbs_row_t rows[$];

    // 100 MHz clock
    always #5 mclk = ~mclk;

    sbs_port u_sbs_port (.mclk(mclk), .srst(srst), .addr_upper(addr_upper),
        .addr_bit1(addr_bit1), .addr_bit0(addr_bit0),
        .ctrl_addr_load_n(ctrl_addr_load_n),
        .proc_addr_load_n(proc_addr_load_n), .burst_step_n(burst_step_n),
        .chip_sel_main_n(chip_sel_main_n), .chip_sel_hi(chip_sel_hi),
        .chip_sel_low_two(chip_sel_low_two), .lane_a_wr_n(lane_a_wr_n),
        .lane_b_wr_n(lane_b_wr_n), .lane_c_wr_n(lane_c_wr_n),
        .lane_d_wr_n(lane_d_wr_n), .lane_wr_gate_n(lane_wr_gate_n),
        .all_byte_wr_n(all_byte_wr_n), .out_en_n(out_en_n),
        .linear_order_sel_n(linear_order_sel_n), .sleep_req(sleep_req),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

    sbs_master u_sbs_master (.mclk(mclk), .addr_upper(addr_upper),
        .addr_bit1(addr_bit1), .addr_bit0(addr_bit0),
        .ctrl_addr_load_n(ctrl_addr_load_n),
        .proc_addr_load_n(proc_addr_load_n), .burst_step_n(burst_step_n),
        .chip_sel_main_n(chip_sel_main_n), .chip_sel_hi(chip_sel_hi),
        .chip_sel_low_two(chip_sel_low_two), .lane_a_wr_n(lane_a_wr_n),
        .lane_b_wr_n(lane_b_wr_n), .lane_c_wr_n(lane_c_wr_n),
        .lane_d_wr_n(lane_d_wr_n), .lane_wr_gate_n(lane_wr_gate_n),
        .all_byte_wr_n(all_byte_wr_n), .out_en_n(out_en_n),
        .linear_order_sel_n(linear_order_sel_n), .sleep_req(sleep_req),
        .data_in(data_in));

    // ------------------------------------------------------------
    // Expected read pipeline: data stands two edges after issue
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        pv <= {pv[0], cur_v};
        pd0 <= cur_d;
        pd1 <= pd0;
    end

    // Mid-cycle check; the enable gating is expected without delay
    always @(negedge mclk) begin
        if (chk_on) begin
            chk_bit("data_oe", pv[1] & ~out_en_n & ~sleep_req,
                data_oe);
            if (pv[1] & ~out_en_n & ~sleep_req) begin
                chk_word("data_out", pd1, data_out);
            end
        end
    end

    task automatic chk_bit(input string nm, input logic e, input logic s);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %b seen %b", nm, e, s);
        end
    endtask

    task automatic chk_word(input string nm, input logic [DW-1:0] e,
            input logic [DW-1:0] s);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    // ------------------------------------------------------------
    // Row building and driving
    // ------------------------------------------------------------
    function automatic sbs_row_t mk(input int k, input int a,
            input logic [2:0] s, input logic [5:0] w, input int st,
            input logic [DW-1:0] d, input int ev, input logic [DW-1:0] ed,
            input int x);
        mk = '{2'(k), AW'(a), s, w, 1'(st), d, 1'(ev), ed, 2'(x)};
    endfunction

    task automatic add(input int k, input int a, input logic [2:0] s,
            input logic [5:0] w, input int st, input logic [DW-1:0] d,
            input int ev, input logic [DW-1:0] ed);
        rows.push_back(mk(k, a, s, w, st, d, ev, ed, 0));
    endtask

    // x carries {out_en_n, sleep_req} for the same edge
    task automatic go(input sbs_row_t r);
        u_sbs_master.cyc(r.k, r.a, r.s, r.w, r.st, r.d);
        u_sbs_master.misc(r.x[1], r.x[0], lin_sel);
        cur_v <= r.ev;
        cur_d <= r.ed;
    endtask

    // Reset is held n+1 cycles; the order pin moves only inside it
    task automatic do_reset(input int n);
        @(posedge mclk);
        chk_on = 1'b0;
        srst <= 1'b1;
        cur_v <= 1'b0;
        repeat (n) @(posedge mclk);
        u_sbs_master.misc(1'b0, 1'b0, lin_sel);
        @(negedge mclk);
        chk_bit("data_oe", 1'b0, data_oe);
        @(posedge mclk);
        srst <= 1'b0;
        chk_on = 1'b1;
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (3000) @(posedge mclk);
        err_count++;
        $display("MISMATCH run_length expected end seen timeout");
        give_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset(20);
        add(1, 4, SON, GW, 1, D4, 0, '0);
        add(1, 5, SON, GW, 1, D5, 0, '0);
        add(1, 6, SON, GW, 1, D6, 0, '0);
        add(1, 7, SON, GW, 1, D7, 0, '0);
        add(1, 4, SON, BAC, 1, DF, 0, '0);
        add(1, 5, SON, NOG, 1, DF, 1, D5);
        add(1, 4, SON, RD, 1, '0, 1, DM);
        add(2, 6, SON, GW, 1, DF, 1, D6);
        add(0, 0, SON, GW, 1, DN, 0, '0);
        add(1, 6, SON, RD, 1, '0, 1, DN);
        add(2, 4, SMAIN, RD, 1, '0, 1, DN);
        add(1, 4, SMAIN, RD, 1, '0, 0, '0);
        add(0, 0, SON, GW, 0, DF, 0, '0);
        add(1, 7, SON, RD, 1, '0, 1, D7);
        add(2, 4, SHI, RD, 1, '0, 0, '0);
        add(0, 0, SON, RD, 0, '0, 0, '0);
        add(2, 4, SLOW, RD, 1, '0, 0, '0);
        add(0, 0, SON, RD, 1, '0, 0, '0);
        add(2, 5, SON, RD, 1, '0, 1, D5);
        add(0, 0, SOFF, RD, 1, '0, 1, D5);
        add(0, 0, SOFF, RD, 0, '0, 1, DM);
        add(0, 0, SOFF, RD, 0, '0, 1, D7);
        add(0, 0, SOFF, RD, 0, '0, 1, DN);
        add(0, 0, SOFF, RD, 0, '0, 1, D5);
        add(1, 0, SMAIN, RD, 1, '0, 0, '0);
        add(0, 0, SON, RD, 1, '0, 0, '0);
        foreach (rows[i]) go(rows[i]);
        // Output enable cuts the drive within the beat it changes
        go(mk(1, 7, SON, RD, 1, '0, 1, D7, 0));
        go(mk(0, 0, SON, RD, 1, '0, 1, D7, 0));
        go(mk(1, 0, SMAIN, RD, 1, '0, 0, '0, 2));
        go(mk(0, 0, SON, RD, 1, '0, 0, '0, 0));
        // Sleep mid-read, a write while asleep must be lost
        go(mk(1, 7, SON, RD, 1, '0, 1, D7, 0));
        go(mk(1, 0, SMAIN, RD, 1, '0, 0, '0, 1));
        go(mk(1, 7, SON, GW, 1, DF, 0, '0, 1));
        go(mk(1, 7, SON, RD, 1, '0, 1, D7, 0));
        go(mk(1, 0, SMAIN, RD, 1, '0, 0, '0, 0));
        go(mk(0, 0, SON, RD, 1, '0, 0, '0, 0));
        // Linear order after a reset; the array keeps its contents
        lin_sel = 1'b0;
        do_reset(3);
        go(mk(1, 5, SON, RD, 1, '0, 1, D5, 0));
        go(mk(0, 0, SOFF, RD, 0, '0, 1, DN, 0));
        go(mk(0, 0, SOFF, RD, 0, '0, 1, D7, 0));
        go(mk(0, 0, SOFF, RD, 0, '0, 1, DM, 0));
        go(mk(0, 0, SOFF, RD, 0, '0, 1, D5, 0));
        go(mk(1, 0, SMAIN, RD, 1, '0, 0, '0, 0));
        repeat (3) go(mk(0, 0, SON, RD, 1, '0, 0, '0, 0));
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
